// ==== hdl/bbr_remap.sv ====
// Bit-band remapper between core accesses and the underlying memory port
`default_nettype none
module bbr_remap
    import bbr_pkg::*;
(
    input  wire logic              I_REF_CLK,
    input  wire logic              I_RST_N,
    input  wire logic              I_REQ_VALID,
    input  wire bbr_pkg::bbr_req_s I_REQ,
    output var  logic              O_REQ_READY,
    output var  logic              O_RSP_VALID,
    output var  logic [31:0]       O_RSP_RDATA,
    output var  logic              O_RSP_FAULT,
    output var  logic              O_MEM_VALID,
    output var  bbr_pkg::bbr_req_s O_MEM,
    input  wire logic              I_MEM_READY,
    input  wire logic              I_MEM_RSP_VALID,
    input  wire logic [31:0]       I_MEM_RDATA
);
    import bbr_pkg::*;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic is_alias(input logic [31:0] a);
        return (a[31:ALIAS_LSB] == ALIAS_SEL) || (a[31:ALIAS_LSB] == PERI_ALIAS_SEL);
    endfunction

    // Offset = byte*32 + bit*4, so the byte is addr[24:5] and bit is addr[4:2]
    function automatic logic [31:0] target_byte(input logic [31:0] a);
        logic [31:0] base;
        base = (a[31:REGION_LSB] == PERI_TOP) ? PERI_BASE : SRAM_BASE;
        return base | {12'h000, a[24:5]};
    endfunction

    function automatic logic [2:0] target_bit(input logic [31:0] a);
        return a[4:2];
    endfunction

    logic       req_alias;
    logic       req_peri_alias;
    logic       refuse;
    logic       remap;
    assign req_alias      = is_alias(I_REQ.addr);
    assign req_peri_alias = I_REQ.addr[31:ALIAS_LSB] == PERI_ALIAS_SEL;
    // Peripheral region never executes
    assign refuse = I_REQ.fetch && (I_REQ.addr[31:REGION_LSB] == PERI_TOP);
    assign remap  = req_alias && !I_REQ.fetch;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    bbr_state_e state;
    bbr_req_s   held;
    logic [2:0] bitpos;
    logic [1:0] lane;
    logic       newbit;

    // Target byte sits in lane l of the little-endian data bus
    function automatic logic [31:0] lane_mask(input logic [1:0] l, input logic [2:0] b);
        return 32'h0000_0001 << {l, b};
    endfunction

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state       <= ST_IDLE;
            held        <= '0;
            bitpos      <= 3'h0;
            lane        <= 2'h0;
            newbit      <= 1'b0;
            O_REQ_READY <= 1'b0;
            O_RSP_VALID <= 1'b0;
            O_RSP_RDATA <= 32'h0000_0000;
            O_RSP_FAULT <= 1'b0;
            O_MEM_VALID <= 1'b0;
            O_MEM       <= '0;
        end else begin
            O_RSP_VALID <= 1'b0;
            O_RSP_FAULT <= 1'b0;
            case (state)
                ST_IDLE: begin
                    O_REQ_READY <= 1'b1;
                    if (I_REQ_VALID && O_REQ_READY) begin
                        O_REQ_READY <= 1'b0;
                        held        <= I_REQ;
                        if (refuse) begin
                            O_RSP_VALID <= 1'b1;
                            O_RSP_FAULT <= 1'b1;
                            O_RSP_RDATA <= 32'h0000_0000;
                            O_REQ_READY <= 1'b1;
                        end else if (remap) begin
                            bitpos      <= target_bit(I_REQ.addr);
                            // Byte lane comes from the unaligned target byte address
                            lane        <= I_REQ.addr[6:5];
                            newbit      <= I_REQ.wdata[0];
                            O_MEM.addr  <= target_byte(I_REQ.addr) &
                                           (I_REQ.size == SIZE_WORD ? 32'hFFFF_FFFC :
                                            I_REQ.size == SIZE_HALF ? 32'hFFFF_FFFE :
                                            32'hFFFF_FFFF);
                            O_MEM.size  <= I_REQ.size;
                            O_MEM.write <= 1'b0;
                            O_MEM.fetch <= 1'b0;
                            O_MEM.wdata <= 32'h0000_0000;
                            O_MEM_VALID <= 1'b1;
                            state       <= ST_RD;
                        end else begin
                            O_MEM       <= I_REQ;
                            O_MEM_VALID <= 1'b1;
                            state       <= ST_DIR;
                        end
                    end
                end
                ST_DIR: begin
                    if (I_MEM_READY && O_MEM_VALID) begin
                        O_MEM_VALID <= 1'b0;
                    end
                    if (I_MEM_RSP_VALID) begin
                        O_RSP_VALID <= 1'b1;
                        O_RSP_RDATA <= I_MEM_RDATA;
                        O_REQ_READY <= 1'b1;
                        state       <= ST_IDLE;
                    end
                end
                ST_RD: begin
                    if (I_MEM_READY && O_MEM_VALID) begin
                        O_MEM_VALID <= 1'b0;
                    end
                    if (I_MEM_RSP_VALID) begin
                        if (held.write) begin
                            // Modify only the target bit, byte lane from low address bits
                            O_MEM.write <= 1'b1;
                            O_MEM.wdata <= newbit ? (I_MEM_RDATA | lane_mask(lane, bitpos))
                                                  : (I_MEM_RDATA & ~lane_mask(lane, bitpos));
                            O_MEM_VALID <= 1'b1;
                            state       <= ST_WR;
                        end else begin
                            O_RSP_VALID <= 1'b1;
                            O_RSP_RDATA <= {31'h0, |(I_MEM_RDATA &
                                           lane_mask(lane, bitpos))};
                            O_REQ_READY <= 1'b1;
                            state       <= ST_IDLE;
                        end
                    end
                end
                ST_WR: begin
                    if (I_MEM_READY && O_MEM_VALID) begin
                        O_MEM_VALID <= 1'b0;
                    end
                    if (I_MEM_RSP_VALID) begin
                        O_RSP_VALID <= 1'b1;
                        O_RSP_RDATA <= 32'h0000_0000;
                        O_REQ_READY <= 1'b1;
                        state       <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Checks: request side
    // ----------------------------------------
    a_fetch_refused: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE && I_REQ_VALID && O_REQ_READY && refuse)
        |=> O_RSP_FAULT && O_RSP_VALID && !O_MEM_VALID)
        else $error("peripheral fetch not refused");

    a_refuse_ready: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE && I_REQ_VALID && O_REQ_READY && refuse)
        |=> O_REQ_READY && state == ST_IDLE)
        else $error("refused fetch left the sequencer busy");

    a_fault_paired: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        O_RSP_FAULT |-> O_RSP_VALID && O_RSP_RDATA == 32'h0000_0000)
        else $error("fault shown without an answer");

    a_peri_no_exec: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        O_MEM_VALID |-> !(O_MEM.fetch && O_MEM.addr[31:REGION_LSB] == PERI_TOP))
        else $error("peripheral fetch reached memory");

    a_ready_busy: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state != ST_IDLE) |-> !O_REQ_READY)
        else $error("new request accepted while busy");

    a_idle_quiet: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE) |-> !O_MEM_VALID)
        else $error("memory request left standing in idle");

    a_state_onehot: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        $onehot(state))
        else $error("sequencer state not one-hot");

    a_size_kept: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE && I_REQ_VALID && O_REQ_READY && !refuse)
        |=> O_MEM.size == $past(I_REQ.size))
        else $error("access size changed");

    a_direct_pass: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE && I_REQ_VALID && O_REQ_READY && !refuse && !remap)
        |=> O_MEM == $past(I_REQ))
        else $error("direct access altered");

    a_alias_fetch: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE && I_REQ_VALID && O_REQ_READY && req_alias && I_REQ.fetch
         && !refuse)
        |=> state == ST_DIR && O_MEM.addr == $past(I_REQ.addr))
        else $error("alias fetch was remapped");

    // ----------------------------------------
    // Checks: address mapping
    // ----------------------------------------
    a_alias_map: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE && I_REQ_VALID && O_REQ_READY && remap && I_REQ.size == SIZE_BYTE)
        |=> O_MEM.addr[19:0] == $past(I_REQ.addr[24:5]) && O_MEM.addr[31:20] ==
            ($past(req_peri_alias) ? PERI_BASE[31:20] : SRAM_BASE[31:20]))
        else $error("alias address mapped wrongly");

    a_remap_read: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE && I_REQ_VALID && O_REQ_READY && remap)
        |=> state == ST_RD && !O_MEM.write)
        else $error("alias access not remapped to a read");

    a_lane_pick: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE && I_REQ_VALID && O_REQ_READY && remap)
        |=> lane == $past(I_REQ.addr[6:5]) && bitpos == $past(I_REQ.addr[4:2]))
        else $error("target lane or bit picked wrongly");

    a_low_region: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_RD)
        |-> O_MEM.addr[31:20] == SRAM_BASE[31:20] || O_MEM.addr[31:20] == PERI_BASE[31:20])
        else $error("remapped access left the lowest megabyte");

    a_word_aligned: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_RD && held.size == SIZE_WORD) |-> O_MEM.addr[1:0] == 2'h0)
        else $error("remapped word access not aligned");

    a_half_aligned: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_RD && held.size == SIZE_HALF) |-> O_MEM.addr[0] == 1'b0)
        else $error("remapped halfword access not aligned");

    // ----------------------------------------
    // Checks: memory port and bit update
    // ----------------------------------------
    a_mem_hold: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (O_MEM_VALID && !I_MEM_READY) |=> O_MEM_VALID && $stable(O_MEM))
        else $error("memory request dropped before it was taken");

    a_rd_phase: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_RD) |-> !O_MEM.write)
        else $error("first half of update is not a read");

    a_wr_phase: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_WR) |-> O_MEM.write && O_MEM.size == held.size)
        else $error("write-back of wrong kind or size");

    a_held_bit: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_IDLE && I_REQ_VALID && O_REQ_READY && remap)
        |=> newbit == $past(I_REQ.wdata[0]))
        else $error("new bit value not taken from bit 0");

    a_rmw_backtoback: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_RD && I_MEM_RSP_VALID && held.write)
        |=> O_MEM_VALID && O_MEM.write && $stable(O_MEM.addr))
        else $error("write-back not issued at once to same address");

    a_bit_written: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_WR && O_MEM_VALID)
        |-> O_MEM.wdata[{lane, bitpos}] == newbit)
        else $error("target bit not written from bit 0");

    a_others_kept: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_RD && I_MEM_RSP_VALID && held.write)
        |=> (O_MEM.wdata | lane_mask(lane, bitpos))
            == ($past(I_MEM_RDATA) | lane_mask(lane, bitpos)))
        else $error("write-back disturbed other bits");

    // ----------------------------------------
    // Checks: answers
    // ----------------------------------------
    a_read_onebit: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_RD && I_MEM_RSP_VALID && !held.write)
        |=> O_RSP_VALID && O_RSP_RDATA[31:1] == 31'h0)
        else $error("alias read returned more than one bit");

    a_read_value: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_RD && I_MEM_RSP_VALID && !held.write)
        |=> !O_RSP_FAULT && O_RSP_RDATA[0] == $past(I_MEM_RDATA[{lane, bitpos}]))
        else $error("alias read returned the wrong bit");

    a_dir_answer: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_DIR && I_MEM_RSP_VALID)
        |=> O_RSP_VALID && !O_RSP_FAULT && O_RSP_RDATA == $past(I_MEM_RDATA))
        else $error("direct read data altered");

    a_wr_answer: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (state == ST_WR && I_MEM_RSP_VALID)
        |=> O_RSP_VALID && !O_RSP_FAULT && O_RSP_RDATA == 32'h0000_0000 && O_REQ_READY)
        else $error("alias write not answered after write-back");
endmodule
`default_nettype wire

// ==== hdl/bbr_pkg.sv ====
// Package for the bit-band remapper: address map, access types, transfer structs
`default_nettype none
package bbr_pkg;
    localparam logic [31:0] SRAM_BASE       = 32'h2000_0000;
    localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] PERI_BASE       = 32'h4000_0000;
    localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
    localparam logic [2:0]  REGION_TOP      = 3'h2;
    localparam logic [2:0]  PERI_TOP        = 3'h2;
    localparam logic [6:0]  ALIAS_SEL       = 7'h11;
    localparam logic [6:0]  PERI_ALIAS_SEL  = 7'h21;
    localparam int          ALIAS_LSB       = 25;
    localparam int          REGION_LSB      = 29;
    localparam logic [1:0]  SIZE_BYTE       = 2'h0;
    localparam logic [1:0]  SIZE_HALF       = 2'h1;
    localparam logic [1:0]  SIZE_WORD       = 2'h2;

    typedef struct packed {
        logic [31:0] addr;
        logic [1:0]  size;
        logic        write;
        logic        fetch;
        logic [31:0] wdata;
    } bbr_req_s;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_DIR   = 4'b0010,
        ST_RD    = 4'b0100,
        ST_WR    = 4'b1000
    } bbr_state_e;
endpackage
`default_nettype wire

// ==== verif/bbr_mem_model.sv ====
// Memory model that answers the remapper's memory port
`default_nettype none
module bbr_mem_model
    import bbr_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_slow,
    input  wire logic              i_mem_valid,
    input  wire bbr_pkg::bbr_req_s i_mem,
    output var  logic              o_ready,
    output var  logic              o_rsp_valid,
    output var  logic [31:0]       o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [29:0]];
    logic        tick;
    logic        take;
    // Slow mode accepts only every other cycle
    assign o_ready = i_mem_valid && (!i_slow || tick);
    assign take    = i_mem_valid && o_ready;
    always @(posedge i_clk or negedge i_rst_n) begin
        logic [31:0] w;
        logic [3:0]  be;
        if (!i_rst_n) begin
            tick <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rdata <= 32'h0;
        end else begin
            tick <= ~tick;
            o_rsp_valid <= take;
            o_rdata <= ~o_rdata;
            if (take) begin
                w = mem.exists(i_mem.addr[31:2]) ? mem[i_mem.addr[31:2]] : 32'hA5A5_A5A5;
                be = (i_mem.size == SIZE_WORD) ? 4'hF :
                     (i_mem.size == SIZE_HALF) ? 4'h3 << i_mem.addr[1:0] :
                     4'h1 << i_mem.addr[1:0];
                for (int k = 0; k < 4; k++)
                    if (i_mem.write && be[k]) w[8*k+:8] = i_mem.wdata[8*k+:8];
                mem[i_mem.addr[31:2]] = w;
                o_rdata <= w;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/bbr_remap_tb_top.sv ====
// Testbench for the bit-band remapper
`default_nettype none
module bbr_remap_tb_top;
    import bbr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, rq_v, rq_rdy, rs_v, rs_f, m_v, m_rdy, m_rs, slow, flt;
    logic [31:0] rs_d, m_d, rd;
    bbr_req_s    rq, m;
    bbr_req_s    mlog[$];
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    bbr_remap bbr_remap_i (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_REQ_VALID(rq_v),
        .I_REQ(rq), .O_REQ_READY(rq_rdy), .O_RSP_VALID(rs_v), .O_RSP_RDATA(rs_d),
        .O_RSP_FAULT(rs_f), .O_MEM_VALID(m_v), .O_MEM(m), .I_MEM_READY(m_rdy),
        .I_MEM_RSP_VALID(m_rs), .I_MEM_RDATA(m_d));
    bbr_mem_model bbr_mem_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
        .i_mem_valid(m_v), .i_mem(m), .o_ready(m_rdy), .o_rsp_valid(m_rs), .o_rdata(m_d));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Log memory requests taken at the next rising edge
    always @(negedge clk) if (m_v === 1'b1 && m_rdy === 1'b1) mlog.push_back(m);
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        if (num_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic w,
                       input logic f, input logic [31:0] d);
        mlog.delete();
        rq = '{addr: a, size: s, write: w, fetch: f, wdata: d};
        rq_v = 1'b1;
        while (rq_rdy !== 1'b1) begin @(posedge clk); #1; end
        @(posedge clk);
        #1 rq_v = 1'b0;
        while (rs_v !== 1'b1) begin @(posedge clk); #1; end
        rd = rs_d;
        flt = rs_f;
    endtask
    task automatic t_direct;
        acc(32'h2000_0004, SIZE_WORD, 1'b1, 1'b0, 32'h1122_3344);
        chk("dir addr", 32'h2000_0004, mlog[0].addr);
        acc(32'h2000_0005, SIZE_BYTE, 1'b0, 1'b0, 32'h0);
        chk("lane1", 32'h0000_0033, (rd >> 8) & 32'hFF);
        acc(32'h4000_0010, SIZE_HALF, 1'b1, 1'b0, 32'h0000_BEEF);
        chk("peri size", {30'h0, SIZE_HALF}, {30'h0, mlog[0].size});
    endtask
    task automatic t_sram_alias;
        acc(32'h2200_00BC, SIZE_WORD, 1'b1, 1'b0, 32'hFFFF_FFFF);
        chk("rmw count", 32'h2, 32'(mlog.size()));
        chk("rmw order", 32'h1, {31'h0, mlog[1].write & ~mlog[0].write});
        chk("rmw addr", 32'h2000_0004, mlog[1].addr);
        chk("rmw data", 32'h1122_B344, mlog[1].wdata);
        acc(32'h2200_00A0, SIZE_WORD, 1'b1, 1'b0, 32'hFFFF_FFFE);
        acc(32'h2000_0004, SIZE_WORD, 1'b0, 1'b0, 32'h0);
        chk("cleared", 32'h1122_B244, rd);
        for (int b = 0; b < 8; b++) begin
            acc(32'h2200_00A0 + 32'(b * 4), SIZE_WORD, 1'b0, 1'b0, 32'h0);
            chk("alias rd", (32'hB2 >> b) & 32'h1, rd);
        end
        acc(32'h23FF_FFFC, SIZE_WORD, 1'b0, 1'b0, 32'h0);
        chk("top addr", 32'h200F_FFFC, mlog[0].addr);
        chk("top bit", 32'h1, rd);
    endtask
    task automatic t_peri_alias;
        slow = 1'b1;
        acc(32'h4200_040C, SIZE_BYTE, 1'b1, 1'b0, 32'h0000_0001);
        chk("p addr", 32'h4000_0020, mlog[1].addr);
        chk("p size", {30'h0, SIZE_BYTE}, {30'h0, mlog[1].size});
        chk("p data", 32'h0000_00AD, mlog[1].wdata & 32'hFF);
        acc(32'h4200_040C, SIZE_HALF, 1'b0, 1'b0, 32'h0);
        chk("p hsize", {30'h0, SIZE_HALF}, {30'h0, mlog[0].size});
        chk("p rd", 32'h1, rd);
        slow = 1'b0;
    endtask
    task automatic t_fetch;
        acc(32'h4200_0000, SIZE_WORD, 1'b0, 1'b1, 32'h0);
        chk("alias fault", 32'h1, {31'h0, flt});
        chk("no mem", 32'h0, 32'(mlog.size()));
        acc(32'h4000_0000, SIZE_WORD, 1'b0, 1'b1, 32'h0);
        chk("peri fault", 32'h1, {31'h0, flt});
        acc(32'h2200_0004, SIZE_WORD, 1'b0, 1'b1, 32'h0);
        chk("fetch addr", 32'h2200_0004, mlog[0].addr);
        chk("fetch ok", 32'h0, {31'h0, flt});
    endtask
    initial begin
        rst_n = 1'b0;
        rq_v = 1'b0;
        rq = '0;
        slow = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        #1;
        t_direct();
        t_sram_alias();
        t_peri_alias();
        t_fetch();
        report_and_stop();
    end
endmodule
`default_nettype wire
